// File: rtl/isdnl1_map.svh
// Constants of the layer-1 activation state machine: command and
// indication codes, transmit info encodings and timer counts.
// Assumes a 200 MHz core clock and a 4-bit command/indication channel.
`ifndef ISDNL1_MAP_SVH
`define ISDNL1_MAP_SVH

// Command codes
`define L1_CMD_DEACT_REQ      4'h0
`define L1_CMD_FSM_RESET      4'h1
`define L1_CMD_SINGLE_PULSE   4'h2
`define L1_CMD_CONT_PULSE     4'h3
`define L1_CMD_NOT_SYNC       4'h4
`define L1_CMD_ACT_REQ        4'h8
`define L1_CMD_ACT_REQ_LOOP   4'ha
`define L1_CMD_SWITCH_THRU    4'hc
`define L1_CMD_SWITCH_LOOP    4'he
`define L1_CMD_DEACT_CONFIRM  4'hf

// Indication codes
`define L1_IND_TIMING         4'h0
`define L1_IND_NOT_SYNC       4'h4
`define L1_IND_ACT_REQ        4'h8
`define L1_IND_CODE_VIOL      4'hb
`define L1_IND_ACT_DONE       4'hc
`define L1_IND_DEACT_DONE     4'hf

// Transmit info selector encodings
`define L1_TX_INFO0           3'h0
`define L1_TX_INFO2           3'h1
`define L1_TX_INFO4           3'h2
`define L1_TX_SINGLE          3'h3
`define L1_TX_CONT            3'h4

// Timers: figures in ms, clock in MHz, counts derived
`define L1_CLK_MHZ            200
`define L1_INFO0_MS           16
`define L1_DEACT_MS           32
`define L1_INFO0_CYCLES       (`L1_INFO0_MS * 1000 * `L1_CLK_MHZ)
`define L1_DEACT_CYCLES       (`L1_DEACT_MS * 1000 * `L1_CLK_MHZ)
`define L1_TMR_W              23

`endif

// File: rtl/isdnl1_pkg.sv
// Types of the layer-1 activation state machine.
// Assumes the constants header is included by each user.
package isdnl1_pkg;

    typedef enum logic [3:0]
    {
        ST_RESET,
        ST_DEACT,
        ST_INFO0_SEEN,
        ST_PEND_ACT,
        ST_WAIT_SWITCH,
        ST_ACTIVE,
        ST_LOST_ST,
        ST_LOST_UP,
        ST_PEND_DEACT,
        ST_WAIT_CONFIRM,
        ST_TEST_SINGLE,
        ST_TEST_CONT
    } isdnl1_state_t;

endpackage : isdnl1_pkg

// File: rtl/isdnl1_sync.sv
// Two-flop synchroniser for a bundle of line-receiver levels.
// Assumes the inputs are asynchronous levels from the analog front end.
`timescale 1ns/10ps
module isdnl1_sync #(
    parameter int WIDTH = 4
)
(
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    // Levels
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_r;

    // Two flops per bit; the first is read only by the second
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_r  <= '0;
            syncOut <= '0;
        end
        else
        begin
            meta_r  <= asyncIn;
            syncOut <= meta_r;
        end
    end

endmodule : isdnl1_sync

// File: rtl/isdnl1_fsm.sv
// Layer-1 activation/deactivation state machine for the S/T transceiver,
// NT and LT-S modes, driven by commands sampled once per highway frame.
// Assumes frame strobe and commands come from logic on core_clk, and line
// receiver status comes asynchronously from the analog front end.
`timescale 1ns/10ps
`include "isdnl1_map.svh"

// Contract
// - Deactivated: transmit nothing, both-side activation
// - NT: terminal signal gives activation-request indication
// - NT: activation command sends INFO 2, loop option
// - NT: INFO 3 seen, keep INFO 2 until switch
// - NT: switch-through sends INFO 4, loop option
// - Lost receive sync when active: lost framing
// - NT: upstream-not-sync command sends INFO 2
// - Deactivation request sends INFO 0
// - Done after 16 ms INFO 0 or 32 ms
// - Wait for confirmation after deactivation
// - Confirmation returns to deactivated, detection enabled
// - Reset command unconditional, INFO 0, ignore line
// - Test commands send single or continuous pulses
// - NT: timing indication while deactivating
// - LT-S: timing indication while deactivated with INFO 0 seen
// - Not-sync and activation-complete indications
// - Code violation indication only when enabled
// - LT-S: INFO 0 or command sends INFO 2
// - LT-S: active holds INFO 4 until exit
// - LT-S: lost sync sends INFO 2, back on INFO 3
// - Reset state reports timing indication
// - Loop 2 forces D echo bit low
module isdnl1_fsm
    import isdnl1_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Configuration
    input  wire logic       ltsMode,
    input  wire logic       codeViolationReportEn,
    // Command channel
    input  wire logic       frameStrobe,
    input  wire logic [3:0] cmdCode,
    output logic      [3:0] indCode,
    // Line receiver status
    input  wire logic       rxInfo0,
    input  wire logic       rxInfo3,
    input  wire logic       rxSynced,
    input  wire logic       rxCodeViol,
    // Line transmitter control
    output logic      [2:0] txInfoSel,
    output logic            loop2Closed,
    output logic            channelsTransparent,
    output logic            echoBitForceZero
);

    // Synchronised line status
    logic [3:0] rxSyncd;
    logic       info0Seen;
    logic       info3Seen;
    logic       syncSeen;
    logic       cvSeen;

    isdnl1_sync #(
        .WIDTH (4)
    ) u_sync (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .asyncIn  ({rxCodeViol, rxSynced, rxInfo3, rxInfo0}),
        .syncOut  (rxSyncd)
    );

    assign info0Seen = rxSyncd[0];
    assign info3Seen = rxSyncd[1];
    assign syncSeen  = rxSyncd[2];
    assign cvSeen    = rxSyncd[3];

    // Test command decode
    function automatic logic isTestCmd(input logic [3:0] c);
        isTestCmd = (c == `L1_CMD_SINGLE_PULSE) ||
                    (c == `L1_CMD_CONT_PULSE);
    endfunction : isTestCmd

    // Activation request decode, plain or looped, used in two states
    function automatic logic isActReq(input logic [3:0] c);
        isActReq = (c == `L1_CMD_ACT_REQ) ||
                   (c == `L1_CMD_ACT_REQ_LOOP);
    endfunction : isActReq

    // State and timers
    isdnl1_state_t             state_r;
    isdnl1_state_t             state_nxt;
    logic                      loop_r;
    logic                      loop_nxt;
    logic [`L1_TMR_W-1:0]      info0Tmr_r;
    logic [`L1_TMR_W-1:0]      info0Tmr_nxt;
    logic [`L1_TMR_W+1:0]      deactTmr_r;
    logic [`L1_TMR_W+1:0]      deactTmr_nxt;
    logic [3:0]                indCode_nxt;
    logic [2:0]                txInfoSel_nxt;
    logic                      cmdValid;
    logic                      info0Done;
    logic                      deactDone;

    localparam logic [`L1_TMR_W-1:0] INFO0_LAST =
        `L1_TMR_W'(`L1_INFO0_CYCLES - 1);
    localparam logic [`L1_TMR_W+1:0] DEACT_LAST =
        (`L1_TMR_W+2)'(`L1_DEACT_CYCLES - 1);

    assign cmdValid  = frameStrobe;
    assign info0Done = (info0Tmr_r == INFO0_LAST) && info0Seen;
    assign deactDone = (deactTmr_r == DEACT_LAST);

    // Next state
    always_comb
    begin
        state_nxt = state_r;
        loop_nxt  = loop_r;
        if (cmdValid && cmdCode == `L1_CMD_FSM_RESET)
        begin
            state_nxt = ST_RESET;
            loop_nxt  = 1'b0;
        end
        else if (cmdValid && isTestCmd(cmdCode) &&
                 state_r != ST_TEST_SINGLE &&
                 state_r != ST_TEST_CONT)
        begin
            loop_nxt  = 1'b0;
            state_nxt = (cmdCode == `L1_CMD_SINGLE_PULSE) ?
                        ST_TEST_SINGLE : ST_TEST_CONT;
        end
        else if (cmdValid && cmdCode == `L1_CMD_DEACT_REQ &&
                 state_r != ST_RESET && state_r != ST_DEACT &&
                 state_r != ST_PEND_DEACT &&
                 state_r != ST_WAIT_CONFIRM)
        begin
            state_nxt = ST_PEND_DEACT;
            loop_nxt  = 1'b0;
        end
        else
        begin
            unique case (state_r)
                ST_RESET, ST_TEST_SINGLE, ST_TEST_CONT:
                begin
                    // Line ignored; besides the commands decoded above, leave only on confirmation
                    if (cmdValid && cmdCode == `L1_CMD_DEACT_CONFIRM)
                        state_nxt = ST_DEACT;
                end
                ST_DEACT:
                begin
                    if (cmdValid && isActReq(cmdCode))
                    begin
                        state_nxt = ST_PEND_ACT;
                        loop_nxt  = (cmdCode == `L1_CMD_ACT_REQ_LOOP);
                    end
                    else if (info0Seen)
                        state_nxt = ltsMode ? ST_PEND_ACT
                                            : ST_INFO0_SEEN;
                end
                ST_INFO0_SEEN:
                begin
                    if (cmdValid && isActReq(cmdCode))
                    begin
                        state_nxt = ST_PEND_ACT;
                        loop_nxt  = (cmdCode == `L1_CMD_ACT_REQ_LOOP);
                    end
                end
                ST_PEND_ACT, ST_LOST_ST:
                begin
                    if (info3Seen)
                        state_nxt = ltsMode ? ST_ACTIVE
                                            : ST_WAIT_SWITCH;
                end
                ST_WAIT_SWITCH, ST_LOST_UP:
                begin
                    if (!ltsMode && cmdValid &&
                        (cmdCode == `L1_CMD_SWITCH_THRU ||
                         cmdCode == `L1_CMD_SWITCH_LOOP))
                    begin
                        state_nxt = ST_ACTIVE;
                        loop_nxt  = loop_r ||
                                    (cmdCode == `L1_CMD_SWITCH_LOOP);
                    end
                end
                ST_ACTIVE:
                begin
                    if (!syncSeen)
                        state_nxt = ST_LOST_ST;
                    else if (!ltsMode && cmdValid &&
                             cmdCode == `L1_CMD_NOT_SYNC)
                        state_nxt = ST_LOST_UP;
                    else if (!ltsMode && cmdValid &&
                             cmdCode == `L1_CMD_SWITCH_LOOP)
                        loop_nxt  = 1'b1;
                end
                ST_PEND_DEACT:
                begin
                    if (info0Done || deactDone)
                        state_nxt = ST_WAIT_CONFIRM;
                end
                ST_WAIT_CONFIRM:
                begin
                    if (cmdValid && cmdCode == `L1_CMD_DEACT_CONFIRM)
                        state_nxt = ST_DEACT;
                end
                default:
                    state_nxt = ST_RESET;
            endcase
        end
    end

    // Deactivation timers run only in pending deactivation
    always_comb
    begin
        info0Tmr_nxt = '0;
        deactTmr_nxt = '0;
        if (state_r == ST_PEND_DEACT)
        begin
            deactTmr_nxt = deactTmr_r + 1'b1;
            if (info0Seen)
                info0Tmr_nxt = info0Tmr_r + 1'b1;
        end
    end

    // Transmit info and indication for the next state
    always_comb
    begin
        txInfoSel_nxt = `L1_TX_INFO0;
        indCode_nxt   = `L1_IND_TIMING;
        unique case (state_nxt)
            ST_RESET:
                indCode_nxt = `L1_IND_TIMING;
            ST_DEACT:
                indCode_nxt = (ltsMode && info0Seen) ?
                              `L1_IND_TIMING
                            : `L1_IND_DEACT_DONE;
            ST_INFO0_SEEN:
                indCode_nxt = `L1_IND_ACT_REQ;
            ST_PEND_ACT, ST_WAIT_SWITCH, ST_LOST_UP:
            begin
                txInfoSel_nxt = `L1_TX_INFO2;
                indCode_nxt   = syncSeen ? `L1_IND_ACT_REQ
                                         : `L1_IND_NOT_SYNC;
            end
            ST_LOST_ST:
            begin
                txInfoSel_nxt = `L1_TX_INFO2;
                indCode_nxt   = `L1_IND_NOT_SYNC;
            end
            ST_ACTIVE:
            begin
                txInfoSel_nxt = `L1_TX_INFO4;
                indCode_nxt   = `L1_IND_ACT_DONE;
            end
            ST_PEND_DEACT:
                indCode_nxt = `L1_IND_TIMING;
            ST_WAIT_CONFIRM:
                indCode_nxt = `L1_IND_DEACT_DONE;
            ST_TEST_SINGLE:
                txInfoSel_nxt = `L1_TX_SINGLE;
            ST_TEST_CONT:
                txInfoSel_nxt = `L1_TX_CONT;
            default:
                txInfoSel_nxt = `L1_TX_INFO0;
        endcase
        if (codeViolationReportEn && cvSeen &&
            state_nxt != ST_RESET)
            indCode_nxt = `L1_IND_CODE_VIOL;
    end

    // Registers
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r    <= ST_RESET;
            loop_r     <= 1'b0;
            info0Tmr_r <= '0;
            deactTmr_r <= '0;
            indCode    <= `L1_IND_TIMING;
            txInfoSel  <= `L1_TX_INFO0;
        end
        else
        begin
            state_r    <= state_nxt;
            loop_r     <= loop_nxt;
            info0Tmr_r <= info0Tmr_nxt;
            deactTmr_r <= deactTmr_nxt;
            indCode    <= indCode_nxt;
            txInfoSel  <= txInfoSel_nxt;
        end
    end

    // Loop and transparency outputs from registered state
    assign loop2Closed         = loop_r;
    assign echoBitForceZero    = loop_r;
    assign channelsTransparent = (state_r == ST_ACTIVE);

endmodule : isdnl1_fsm

// File: test/isdnl1_fsm_asserts.sv
// Port checker of the layer-1 activation state machine.
// Assumes it is bound to the state machine and sees its ports only.
`timescale 1ns/10ps
module isdnl1_fsm_asserts
(
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       reset_n,
    // Configuration and command channel
    input wire logic       ltsMode,
    input wire logic       codeViolationReportEn,
    input wire logic       frameStrobe,
    input wire logic [3:0] cmdCode,
    // Results
    input wire logic [3:0] indCode,
    input wire logic [2:0] txInfoSel,
    input wire logic       loop2Closed,
    input wire logic       channelsTransparent,
    input wire logic       echoBitForceZero
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    // Reset state reports timing and sends INFO 0
    reset_state_a: assert property (!$past(reset_n) |->
        indCode == 4'h0 && txInfoSel == 3'h0) else $error("reset state");
    // Echo bit is forced low exactly while loop 2 is closed
    echo_zero_a: assert property (echoBitForceZero == loop2Closed)
        else $error("echo bit not tied to loop");
    // Transparent channels only with INFO 4 going out
    transp_info4_a: assert property (channelsTransparent |->
        txInfoSel == 3'h2) else $error("transparent without INFO 4");
    // Deactivation request from any sending state sends INFO 0 at once
    deact_cmd_a: assert property (frameStrobe && cmdCode == 4'h0 &&
        txInfoSel != 3'h0 && !codeViolationReportEn |=> txInfoSel == 3'h0
        && (ltsMode || indCode == 4'h0)) else $error("deactivation");
    // Test commands pick single or continuous pulses
    test_cmd_a: assert property (frameStrobe && cmdCode[3:1] == 3'h1 &&
        txInfoSel < 3'h3 |=> txInfoSel == ($past(cmdCode[0]) ? 3'h4 : 3'h3))
        else $error("test mode");
    // Reset command holds INFO 0 and timing for the three cycles after the strobe
    reset_cmd_a: assert property (frameStrobe && cmdCode == 4'h1 |=>
        (txInfoSel == 3'h0 && !loop2Closed && indCode == 4'h0)[*3])
        else $error("reset command");
    // Loop 2 closes only on a strobed looped command
    loop_cmd_a: assert property ($rose(loop2Closed) |->
        $past(frameStrobe) && ($past(cmdCode) == 4'ha ||
        $past(cmdCode) == 4'he)) else $error("loop without command");
    // Code violation shown only while reporting is enabled
    viol_gate_a: assert property (indCode == 4'hb |->
        $past(codeViolationReportEn)) else $error("violation ungated");
    // Deactivated and waiting states stay silent
    deact_quiet_a: assert property (indCode == 4'hf |->
        txInfoSel == 3'h0) else $error("sending while deactivated");
endmodule : isdnl1_fsm_asserts

bind isdnl1_fsm isdnl1_fsm_asserts u_chk
(
    .core_clk(core_clk), .reset_n(reset_n), .ltsMode(ltsMode),
    .codeViolationReportEn(codeViolationReportEn),
    .frameStrobe(frameStrobe), .cmdCode(cmdCode), .indCode(indCode),
    .txInfoSel(txInfoSel), .loop2Closed(loop2Closed),
    .channelsTransparent(channelsTransparent),
    .echoBitForceZero(echoBitForceZero)
);

// File: test/isdnl1_ctl_model.sv
// Upstream controller model: one frame strobe every four clocks, and
// the requested command copied onto the channel at every clock.
// Assumes the bench changes its request at the falling clock edge.
`timescale 1ns/10ps
module isdnl1_ctl_model
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Request from the bench
    input  wire logic [3:0] cmdReq,
    // Command channel
    output logic            frameStrobe,
    output logic      [3:0] cmdCode
);
    logic [1:0] frameCnt_r;

    // Frame timing and held command, moved just after the falling edge
    always @(negedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            frameCnt_r  <= 2'h0;
            frameStrobe <= 1'b0;
            cmdCode     <= 4'h1;
        end
        else
        begin
            frameCnt_r  <= frameCnt_r + 2'h1;
            frameStrobe <= (frameCnt_r == 2'h3);
            cmdCode     <= cmdReq;
        end
    end
endmodule : isdnl1_ctl_model

// File: test/tb_top.sv
// Self-checking bench of the activation machine, NT then LT-S mode.
// Assumes the controller model strobes a frame every four clocks.
`timescale 1ns/10ps
module tb_top;
    logic        core_clk, reset_n, ltsMode, codeViolationReportEn;
    logic        frameStrobe, rxInfo0, rxInfo3, rxSynced, rxCodeViol;
    logic        loop2Closed, channelsTransparent, echoBitForceZero;
    logic [3:0]  cmdReq, cmdCode, indCode;
    logic [2:0]  txInfoSel;
    logic [31:0] seed;
    logic [3:0]  badCode [6] = '{4'h5, 4'h6, 4'h7, 4'h9, 4'hb, 4'hd};
    int          fail_count, n_compared, cycles;

    always #2.5 core_clk = ~core_clk;

    isdnl1_fsm dut
    (
        .core_clk(core_clk), .reset_n(reset_n), .ltsMode(ltsMode),
        .codeViolationReportEn(codeViolationReportEn),
        .frameStrobe(frameStrobe), .cmdCode(cmdCode), .indCode(indCode),
        .rxInfo0(rxInfo0), .rxInfo3(rxInfo3), .rxSynced(rxSynced),
        .rxCodeViol(rxCodeViol), .txInfoSel(txInfoSel),
        .loop2Closed(loop2Closed), .channelsTransparent(channelsTransparent),
        .echoBitForceZero(echoBitForceZero)
    );

    isdnl1_ctl_model ctl
    (
        .core_clk(core_clk), .reset_n(reset_n), .cmdReq(cmdReq),
        .frameStrobe(frameStrobe), .cmdCode(cmdCode)
    );

    // Next value of the stimulus shift register
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr

    // Compare one result with its expectation
    task automatic chk(input string what, input logic [3:0] exp,
                       input logic [3:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // Indication and transmit selection together
    task automatic expect_out(input logic [3:0] ind, input logic [2:0] tx);
        chk("indCode", ind, indCode);
        chk("txInfoSel", {1'b0, tx}, {1'b0, txInfoSel});
    endtask : expect_out

    // Request a command and let two frames pass
    task automatic send(input logic [3:0] c);
        cmdReq <= c;
        repeat (8) @(negedge core_clk);
    endtask : send

    // Set line levels and let the synchroniser settle
    task automatic line(input logic i0, input logic i3, input logic sy);
        rxInfo0  = i0;
        rxInfo3  = i3;
        rxSynced = sy;
        repeat (6) @(negedge core_clk);
    endtask : line

    // Counts, verdict and end of run
    task automatic close_out;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    // Cut a hang short
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fail_count++;
            close_out();
        end
    end

    initial
    begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        ltsMode = 1'b0;
        codeViolationReportEn = 1'b0;
        cmdReq = 4'h1;
        rxInfo0 = 1'b0;
        rxInfo3 = 1'b0;
        rxSynced = 1'b0;
        rxCodeViol = 1'b0;
        seed = 32'he807c630;
        repeat (6) @(negedge core_clk);
        reset_n <= 1'b1;
        expect_out(4'h0, 3'h0);
        send(4'hf);
        expect_out(4'hf, 3'h0);
        line(1'b1, 1'b0, 1'b0);
        chk("indCode", 4'h8, indCode);
        send(4'h8);
        expect_out(4'h4, 3'h1);
        line(1'b0, 1'b1, 1'b1);
        chk("txInfoSel", 4'h1, {1'b0, txInfoSel});
        repeat (3)
        begin
            seed = lfsr(seed);
            send(badCode[seed % 6]);
            chk("txInfoSel", 4'h1, {1'b0, txInfoSel});
        end
        send(4'hc);
        expect_out(4'hc, 3'h2);
        chk("channelsTransparent", 4'h1, {3'h0, channelsTransparent});
        send(4'he);
        chk("loop2Closed", 4'h1, {3'h0, loop2Closed});
        chk("echoBitForceZero", 4'h1, {3'h0, echoBitForceZero});
        send(4'h4);
        chk("txInfoSel", 4'h1, {1'b0, txInfoSel});
        send(4'h0);
        expect_out(4'h0, 3'h0);
        send(4'h1);
        line(1'b1, 1'b1, 1'b0);
        expect_out(4'h0, 3'h0);
        send(4'h2);
        chk("txInfoSel", 4'h3, {1'b0, txInfoSel});
        send(4'hf);
        chk("txInfoSel", 4'h0, {1'b0, txInfoSel});
        send(4'h3);
        chk("txInfoSel", 4'h4, {1'b0, txInfoSel});
        reset_n = 1'b0;
        ltsMode = 1'b1;
        cmdReq = 4'h1;
        line(1'b0, 1'b0, 1'b0);
        reset_n <= 1'b1;
        send(4'hf);
        send(4'ha);
        chk("txInfoSel", 4'h1, {1'b0, txInfoSel});
        chk("loop2Closed", 4'h1, {3'h0, loop2Closed});
        line(1'b0, 1'b1, 1'b1);
        chk("txInfoSel", 4'h2, {1'b0, txInfoSel});
        line(1'b0, 1'b0, 1'b0);
        chk("txInfoSel", 4'h1, {1'b0, txInfoSel});
        chk("channelsTransparent", 4'h0, {3'h0, channelsTransparent});
        rxCodeViol = 1'b1;
        line(1'b0, 1'b1, 1'b1);
        expect_out(4'hc, 3'h2);
        codeViolationReportEn = 1'b1;
        line(1'b0, 1'b1, 1'b1);
        chk("indCode", 4'hb, indCode);
        close_out();
    end
endmodule : tb_top
